// ---- inc/pos_status_pkg.sv ----
// What this block does
// - flag done or abnormal end after pulses
// - shared end flags track latest instruction
// - live error: flag, code, 32-bit step
// - short step register when step <= 32767
// - live record overwritten; cancel clears flag
// - restart uncancelled: clear, then set again
// - latched error flag and 32-bit step
// - latched short step when step <= 32767
// - latched record holds until forced reset
// - edited block with positioning: decelerate, stop
// - variable speed without ramp: stop at once
// - refuse edits of table-batch blocks
// - legacy version: variable speed never ramps
package pos_status_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CODE_W = 16;
  localparam int STEP_W = 32;
  localparam int SHORT_W = 16;
  localparam logic [STEP_W-1:0] STEP_SHORT_MAX = 32'h0000_7FFF;

  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_ERR_CODE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_ERR_STEP_LO = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_ERR_STEP_HI = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_ERR_STEP_SHORT = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_LAT_STEP_LO = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_LAT_STEP_HI = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_LAT_STEP_SHORT = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h20;

  localparam int ST_DONE_BIT = 0;
  localparam int ST_ABN_BIT = 1;
  localparam int ST_ERR_BIT = 2;
  localparam int ST_LAT_BIT = 3;
  localparam int ST_LEGACY_BIT = 4;

  localparam int CT_CANCEL_BIT = 0;
  localparam int CT_FRESET_BIT = 1;
  localparam int CT_LEGACY_BIT = 2;

  localparam logic [CODE_W-1:0] CODE_RESET = 16'h0000;
  localparam logic [STEP_W-1:0] STEP_RESET = 32'h0000_0000;
  localparam logic [SHORT_W-1:0] SHORT_RESET = 16'h0000;
  localparam logic LEGACY_RESET = 1'b0;

  typedef enum logic [2:0] {
    KIND_NONE = 3'h0,
    KIND_HOMING = 3'h1,
    KIND_FIXED_FEED = 3'h2,
    KIND_TABLE = 3'h3,
    KIND_ZERO_RET = 3'h4,
    KIND_VAR_SPEED = 3'h5,
    KIND_INC_DRIVE = 3'h6,
    KIND_ABS_DRIVE = 3'h7
  } instr_kind_t;

  typedef enum logic [1:0] {
    ACT_NONE = 2'h0,
    ACT_DECEL = 2'h1,
    ACT_NOW = 2'h2,
    ACT_REFUSE = 2'h3
  } edit_action_t;

  typedef enum logic [1:0] {
    ERR_CLEAR = 2'b00,
    ERR_ACTIVE = 2'b01,
    ERR_REARM = 2'b11
  } err_state_t;
endpackage

// ---- core/error_record.sv ----
`timescale 1ns/1ps
`default_nettype none
module error_record
  import pos_status_pkg::*;
#(
  parameter bit KEEP_FIRST = 1'b0
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic errEvent,
  input wire logic [STEP_W-1:0] errStep,
  input wire logic clear,
  output logic flag,
  output logic [STEP_W-1:0] stepPair,
  output logic [SHORT_W-1:0] stepShort
);
  logic flag_q;
  logic [STEP_W-1:0] step_q;
  logic [SHORT_W-1:0] short_q;
  // later events ignored once held when keeping the first
  wire take = errEvent && !(KEEP_FIRST && flag_q);
  wire fits = errStep <= STEP_SHORT_MAX;

  always_ff @(posedge clock)
  begin
    if (rst || clear)
    begin
      flag_q <= 1'b0;
      step_q <= STEP_RESET;
      short_q <= SHORT_RESET;
    end
    else if (take)
    begin
      flag_q <= 1'b1;
      step_q <= errStep;
      if (fits)
        short_q <= errStep[SHORT_W-1:0];
    end
  end

  assign flag = flag_q;
  assign stepPair = step_q;
  assign stepShort = short_q;
endmodule // error_record
`default_nettype wire

// ---- core/edit_guard.sv ----
`timescale 1ns/1ps
`default_nettype none
module edit_guard
  import pos_status_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic editReq,
  input wire instr_kind_t editKind,
  input wire logic pulseBusy,
  input wire logic accelActive,
  input wire logic legacy,
  output logic stopDecel,
  output logic stopNow,
  output logic refused,
  output logic accepted
);
  function automatic edit_action_t decideAction(instr_kind_t k, logic busy, logic ramp);
    edit_action_t a;
    a = ACT_NONE;
    case (k)
      KIND_TABLE: a = ACT_REFUSE;
      KIND_VAR_SPEED: a = !busy ? ACT_NONE : (ramp ? ACT_DECEL : ACT_NOW);
      KIND_HOMING, KIND_FIXED_FEED, KIND_ZERO_RET,
      KIND_INC_DRIVE, KIND_ABS_DRIVE: a = busy ? ACT_DECEL : ACT_NONE;
      default: a = ACT_NONE;
    endcase
    return a;
  endfunction

  wire rampOn = accelActive && !legacy;
  wire edit_action_t act = decideAction(editKind, pulseBusy, rampOn);
  logic decel_q;
  logic now_q;
  logic refuse_q;
  logic accept_q;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      decel_q <= 1'b0;
      now_q <= 1'b0;
      refuse_q <= 1'b0;
      accept_q <= 1'b0;
    end
    else
    begin
      decel_q <= editReq && act == ACT_DECEL;
      now_q <= editReq && act == ACT_NOW;
      refuse_q <= editReq && act == ACT_REFUSE;
      accept_q <= editReq && act != ACT_REFUSE;
    end
  end

  assign stopDecel = decel_q;
  assign stopNow = now_q;
  assign refused = refuse_q;
  assign accepted = accept_q;
endmodule // edit_guard
`default_nettype wire

// ---- core/positioning_status_and_error_flags.sv ----
`timescale 1ns/1ps
`default_nettype none
module positioning_status_and_error_flags
  import pos_status_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic instrEnd,
  input wire logic instrAbnormal,
  input wire logic opError,
  input wire logic [CODE_W-1:0] opErrorCodeIn,
  input wire logic [STEP_W-1:0] opErrorStepIn,
  input wire logic runRestart,
  input wire logic forcedResetIn,
  input wire logic editReq,
  input wire instr_kind_t editKind,
  input wire logic pulseBusy,
  input wire logic accelActive,
  output logic execDone,
  output logic execAbnormal,
  output logic opErrorFlag,
  output logic latchedErrorFlag,
  output logic pulseStopDecel,
  output logic pulseStopNow,
  output logic editRefused,
  output logic editAccepted
);
  logic done_q;
  logic done_d;
  logic abn_q;
  logic abn_d;
  logic legacy_q;
  logic [CODE_W-1:0] code_q;
  err_state_t err_q;
  err_state_t err_d;
  logic [DATA_W-1:0] rdata_q;
  logic slverr_q;
  logic [STEP_W-1:0] liveStep;
  logic [SHORT_W-1:0] liveShort;
  logic [STEP_W-1:0] latStep;
  logic [SHORT_W-1:0] latShort;

  // bus decode
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire wrCtrl = access && pwrite && paddr == OFS_CTRL;
  wire cancelCmd = wrCtrl && pwdata[CT_CANCEL_BIT];
  wire forcedReset = forcedResetIn || (wrCtrl && pwdata[CT_FRESET_BIT]);
  wire selStatus = paddr == OFS_STATUS;
  wire selCode = paddr == OFS_ERR_CODE;
  wire selLiveLo = paddr == OFS_ERR_STEP_LO;
  wire selLiveHi = paddr == OFS_ERR_STEP_HI;
  wire selLiveShort = paddr == OFS_ERR_STEP_SHORT;
  wire selLatLo = paddr == OFS_LAT_STEP_LO;
  wire selLatHi = paddr == OFS_LAT_STEP_HI;
  wire selLatShort = paddr == OFS_LAT_STEP_SHORT;
  wire selCtrl = paddr == OFS_CTRL;
  wire mapped = selStatus || selCode || selLiveLo || selLiveHi || selLiveShort
    || selLatLo || selLatHi || selLatShort || selCtrl;
  wire latFlag;

  logic [DATA_W-1:0] statusWord;
  always_comb
  begin
    statusWord = '0;
    statusWord[ST_DONE_BIT] = done_q;
    statusWord[ST_ABN_BIT] = abn_q;
    statusWord[ST_ERR_BIT] = err_q == ERR_ACTIVE;
    statusWord[ST_LAT_BIT] = latFlag;
    statusWord[ST_LEGACY_BIT] = legacy_q;
  end

  // zero-extends a 16-bit field into a bus word
  function automatic logic [DATA_W-1:0] busWord(input logic [SHORT_W-1:0] field);
    return {{(DATA_W-SHORT_W){1'b0}}, field};
  endfunction

  wire [DATA_W-1:0] ctrlWord = {{(DATA_W-1){1'b0}}, legacy_q} << CT_LEGACY_BIT;
  wire [DATA_W-1:0] readMux = ({DATA_W{selStatus}} & statusWord)
    | ({DATA_W{selCode}} & busWord(code_q))
    | ({DATA_W{selLiveLo}} & busWord(liveStep[SHORT_W-1:0]))
    | ({DATA_W{selLiveHi}} & busWord(liveStep[STEP_W-1:SHORT_W]))
    | ({DATA_W{selLiveShort}} & busWord(liveShort))
    | ({DATA_W{selLatLo}} & busWord(latStep[SHORT_W-1:0]))
    | ({DATA_W{selLatHi}} & busWord(latStep[STEP_W-1:SHORT_W]))
    | ({DATA_W{selLatShort}} & busWord(latShort))
    | ({DATA_W{selCtrl}} & ctrlWord);

  // read data and error captured in setup, shown in access
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rdata_q <= '0;
      slverr_q <= 1'b0;
    end
    else if (setup)
    begin
      rdata_q <= pwrite ? '0 : readMux;
      slverr_q <= !mapped;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      legacy_q <= LEGACY_RESET;
    else if (wrCtrl)
      legacy_q <= pwdata[CT_LEGACY_BIT];
  end

  // end flags follow the latest finished instruction
  always_comb
  begin
    done_d = done_q;
    abn_d = abn_q;
    if (instrEnd)
    begin
      done_d = !instrAbnormal;
      abn_d = instrAbnormal;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      done_q <= 1'b0;
      abn_q <= 1'b0;
    end
    else
    begin
      done_q <= done_d;
      abn_q <= abn_d;
    end
  end

  // live error flag; a new error beats a cancel
  always_comb
  begin
    case (err_q)
      ERR_CLEAR: err_d = opError ? ERR_ACTIVE : ERR_CLEAR;
      ERR_ACTIVE:
      begin
        if (opError)
          err_d = ERR_ACTIVE;
        else if (cancelCmd)
          err_d = ERR_CLEAR;
        else if (runRestart)
          err_d = ERR_REARM;
        else
          err_d = ERR_ACTIVE;
      end
      ERR_REARM: err_d = ERR_ACTIVE;
      default: err_d = ERR_CLEAR;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      err_q <= ERR_CLEAR;
      code_q <= CODE_RESET;
    end
    else
    begin
      err_q <= err_d;
      if (opError)
        code_q <= opErrorCodeIn;
    end
  end

  error_record #(.KEEP_FIRST(1'b0)) liveRecord (
    .clock(clock),
    .rst(rst),
    .errEvent(opError),
    .errStep(opErrorStepIn),
    .clear(1'b0),
    .flag(),
    .stepPair(liveStep),
    .stepShort(liveShort)
  );

  error_record #(.KEEP_FIRST(1'b1)) latchedRecord (
    .clock(clock),
    .rst(rst),
    .errEvent(opError),
    .errStep(opErrorStepIn),
    .clear(forcedReset),
    .flag(latFlag),
    .stepPair(latStep),
    .stepShort(latShort)
  );

  edit_guard editGuard (
    .clock(clock),
    .rst(rst),
    .editReq(editReq),
    .editKind(editKind),
    .pulseBusy(pulseBusy),
    .accelActive(accelActive),
    .legacy(legacy_q),
    .stopDecel(pulseStopDecel),
    .stopNow(pulseStopNow),
    .refused(editRefused),
    .accepted(editAccepted)
  );

  assign prdata = rdata_q;
  assign pready = 1'b1;
  assign pslverr = access && slverr_q;
  assign execDone = done_q;
  assign execAbnormal = abn_q;
  assign opErrorFlag = err_q == ERR_ACTIVE;
  assign latchedErrorFlag = latFlag;
endmodule // positioning_status_and_error_flags
`default_nettype wire

// ---- verification/pos_status_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module pos_status_properties
  import pos_status_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic instrEnd,
  input wire logic instrAbnormal,
  input wire logic opError,
  input wire logic runRestart,
  input wire logic forcedResetIn,
  input wire logic editReq,
  input wire instr_kind_t editKind,
  input wire logic pulseBusy,
  input wire logic accelActive,
  input wire logic execDone,
  input wire logic execAbnormal,
  input wire logic opErrorFlag,
  input wire logic latchedErrorFlag,
  input wire logic pulseStopDecel,
  input wire logic pulseStopNow,
  input wire logic editRefused,
  input wire logic editAccepted
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  wire ctrlWr = psel && penable && pwrite && paddr == OFS_CTRL;
  wire cancelWr = ctrlWr && pwdata[CT_CANCEL_BIT];
  wire anyFreset = forcedResetIn || (ctrlWr && pwdata[CT_FRESET_BIT]);
  chk_end_flags: assert property (instrEnd |=> execDone != execAbnormal
    && execAbnormal == $past(instrAbnormal)) else $error("end flags wrong");
  chk_err_set: assert property (opError |=> opErrorFlag)
    else $error("error flag not set");
  chk_restart_rearm: assert property (runRestart && opErrorFlag && !opError && !cancelWr
    |=> !opErrorFlag ##1 opErrorFlag) else $error("restart rearm wrong");
  chk_cancel_clear: assert property (cancelWr && opErrorFlag && !opError
    |=> !opErrorFlag) else $error("cancel ignored");
  chk_latch_set: assert property (opError && !anyFreset |=> latchedErrorFlag)
    else $error("latched flag not set");
  chk_latch_hold: assert property (latchedErrorFlag && !anyFreset
    |=> latchedErrorFlag) else $error("latched flag lost");
  chk_freset_clear: assert property (anyFreset |=> !latchedErrorFlag)
    else $error("forced reset ignored");
  chk_decel_stop: assert property (editReq && pulseBusy && editKind inside {KIND_HOMING,
    KIND_FIXED_FEED, KIND_ZERO_RET, KIND_INC_DRIVE, KIND_ABS_DRIVE}
    |=> pulseStopDecel && editAccepted) else $error("no decelerating stop");
  chk_table_refuse: assert property (editReq && editKind == KIND_TABLE
    |=> editRefused && !editAccepted) else $error("table edit not refused");
  chk_var_now: assert property (editReq && editKind == KIND_VAR_SPEED && pulseBusy
    && !accelActive |=> pulseStopNow) else $error("no immediate stop");
  cover property (opError ##1 opErrorFlag);
  cover property (runRestart && opErrorFlag);
  cover property (editReq && editKind == KIND_TABLE);
  cover property (ctrlWr && pwdata[CT_FRESET_BIT] && latchedErrorFlag);
endmodule // pos_status_properties
bind positioning_status_and_error_flags pos_status_properties chk (.*);
`default_nettype wire

// ---- verification/drive_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module drive_model
(
  input wire logic clock,
  input wire logic rst,
  input wire logic start,
  input wire logic ramp,
  input wire logic stopDecel,
  input wire logic stopNow,
  output logic pulseBusy,
  output logic accelActive
);
  int left;
  always @(posedge clock)
  begin
    if (rst || stopNow)
      left <= 0;
    else if (stopDecel)
      left <= 3;
    else if (start && left == 0)
      left <= 30;
    else if (left != 0)
      left <= left - 1;
  end
  // busy follows motion, not the end flags
  assign pulseBusy = left != 0;
  assign accelActive = pulseBusy && ramp;
endmodule // drive_model
`default_nettype wire

// ---- verification/positioning_status_and_error_flags_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module positioning_status_and_error_flags_test
  import pos_status_pkg::*;
;
  logic clock = 1'b0, rst = 1'b1, start = 1'b0, ramp = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [DATA_W-1:0] pwdata = 32'h0, prdata;
  logic instrEnd = 1'b0, instrAbnormal = 1'b0, opError = 1'b0;
  logic runRestart = 1'b0, forcedResetIn = 1'b0, editReq = 1'b0;
  logic [CODE_W-1:0] opErrorCodeIn = 16'h0, c1, c2;
  logic [STEP_W-1:0] opErrorStepIn = 32'h0, s1, s2;
  instr_kind_t editKind = KIND_NONE;
  logic pulseBusy, accelActive, execDone, execAbnormal, opErrorFlag, latchedErrorFlag;
  logic pulseStopDecel, pulseStopNow, editRefused, editAccepted;
  logic [1:0] priv = 2'b00;
  logic [32:0] rdQ[$], edQ[$];
  int n_mismatch = 0, n_tests = 0, cycles = 0, seed = 81650;

  always #50 clock = ~clock;

  positioning_status_and_error_flags dut (.*);
  drive_model drive (.clock, .rst, .start, .ramp, .stopDecel(pulseStopDecel),
    .stopNow(pulseStopNow), .pulseBusy, .accelActive);

  task automatic conclude;
    if (n_mismatch == 0 && n_tests > 0 && rdQ.size() + edQ.size() == 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
      @(posedge clock);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [32:0] e);
    rdQ.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic err(input logic [STEP_W-1:0] s, input logic [CODE_W-1:0] c);
    opError <= 1'b1;
    opErrorStepIn <= s;
    opErrorCodeIn <= c;
    @(posedge clock);
    opError <= 1'b0;
    @(posedge clock);
  endtask

  task automatic fin(input logic ab);
    instrEnd <= 1'b1;
    instrAbnormal <= ab;
    @(posedge clock);
    instrEnd <= 1'b0;
    @(posedge clock);
  endtask

  task automatic go(input logic r);
    while (pulseBusy !== 1'b0)
      @(posedge clock);
    @(posedge clock);
    ramp <= r;
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    repeat (2) @(posedge clock);
  endtask

  task automatic edit(input instr_kind_t k, input logic lg);
    logic tb, dec;
    tb = k == KIND_TABLE;
    dec = pulseBusy && (k inside {KIND_HOMING, KIND_FIXED_FEED, KIND_ZERO_RET,
      KIND_INC_DRIVE, KIND_ABS_DRIVE} || k == KIND_VAR_SPEED && accelActive && !lg);
    edQ.push_back({29'h0, dec, pulseBusy && k == KIND_VAR_SPEED && !dec, tb, !tb});
    editReq <= 1'b1;
    editKind <= k;
    @(posedge clock);
    editReq <= 1'b0;
    repeat (2) @(posedge clock);
  endtask

  always @(posedge clock)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite && rdQ.size() > 0)
      chk({pslverr, prdata}, rdQ.pop_front());
    if ((pulseStopDecel | pulseStopNow | editRefused | editAccepted) === 1'b1)
      chk({29'h0, pulseStopDecel, pulseStopNow, editRefused, editAccepted},
        edQ.size() > 0 ? edQ.pop_front() : 33'h1_FFFF_FFFF);
    cycles++;
    if (cycles == 6000)
    begin
      n_mismatch++;
      conclude();
    end
  end

  initial
  begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(OFS_STATUS, 33'h0);
    rd(8'h24, 33'h1_0000_0000);
    fin(1'b0);
    priv = {execAbnormal, execDone};
    rd(OFS_STATUS, 33'h1);
    fin(1'b1);
    rd(OFS_STATUS, 33'h2);
    chk({31'h0, priv}, 33'h1);
    s1 = $random(seed) & 32'h0000_7FFF;
    s2 = $random(seed) | 32'h0001_0000;
    c1 = 16'($random(seed));
    c2 = 16'($random(seed));
    err(s1, c1);
    rd(OFS_STATUS, 33'hE);
    rd(OFS_ERR_CODE, {17'h0, c1});
    rd(OFS_ERR_STEP_SHORT, {17'h0, s1[15:0]});
    rd(OFS_LAT_STEP_SHORT, {17'h0, s1[15:0]});
    err(s2, c2);
    rd(OFS_ERR_CODE, {17'h0, c2});
    rd(OFS_ERR_STEP_LO, {17'h0, s2[15:0]});
    rd(OFS_ERR_STEP_HI, {17'h0, s2[31:16]});
    rd(OFS_ERR_STEP_SHORT, {17'h0, s1[15:0]});
    rd(OFS_LAT_STEP_LO, {17'h0, s1[15:0]});
    apb(1'b1, OFS_CTRL, 32'h1);
    rd(OFS_STATUS, 33'hA);
    err(s2, c1);
    runRestart <= 1'b1;
    @(posedge clock);
    runRestart <= 1'b0;
    @(posedge clock);
    rd(OFS_STATUS, 33'hE);
    forcedResetIn <= 1'b1;
    @(posedge clock);
    forcedResetIn <= 1'b0;
    @(posedge clock);
    rd(OFS_STATUS, 33'h6);
    rd(OFS_LAT_STEP_LO, 33'h0);
    err(s1, c2);
    apb(1'b1, OFS_CTRL, 32'h2);
    rd(OFS_STATUS, 33'h6);
    rd(OFS_LAT_STEP_SHORT, 33'h0);
    for (int i = 0; i < 8; i++)
    begin
      go(1'b1);
      edit(instr_kind_t'(i), 1'b0);
    end
    go(1'b0);
    edit(KIND_VAR_SPEED, 1'b0);
    apb(1'b1, OFS_CTRL, 32'h4);
    rd(OFS_CTRL, 33'h4);
    go(1'b1);
    edit(KIND_VAR_SPEED, 1'b1);
    edit(KIND_TABLE, 1'b1);
    repeat (4) @(posedge clock);
    conclude();
  end
endmodule // positioning_status_and_error_flags_test
`default_nettype wire
